// *** gdc_cfg.svh ***
// Addresses, field positions, reset values and status codes of the gyro config block.
`ifndef GDC_CFG_SVH
`define GDC_CFG_SVH

// Register and command addresses seen in the address phase.
`define GDC_ADDR_HPF       8'h01
`define GDC_ADDR_LPF       8'h02
`define GDC_ADDR_CAL       8'h03
`define GDC_ADDR_STAT      8'h04
`define GDC_ADDR_SLEEP_IN  8'h05
`define GDC_ADDR_SLEEP_OUT 8'h06
`define GDC_ADDR_STANDBY   8'h07
`define GDC_ADDR_TEMP_RD   8'h08
`define GDC_ADDR_SW_RST    8'h09
`define GDC_ADDR_RATE_RD   8'h0a
`define GDC_ADDR_ZERO_CAL  8'h0c

// Reset images of the three configuration registers.
`define GDC_HPF_RST 8'h21
`define GDC_LPF_RST 8'h06
`define GDC_CAL_RST 8'h00

// Reserved bits that read back fixed at their default level.
`define GDC_HPF_RSV 8'h01
`define GDC_LPF_RSV 8'h00
`define GDC_CAL_RSV 8'h00

// Field positions (least significant bit of each field).
`define GDC_HPF_ON_BIT  1
`define GDC_HPF_CUT_LSB 4
`define GDC_NOTCH_BIT   6
`define GDC_LPF_ORD_LSB 4
`define GDC_LPF_CUT_LSB 0
`define GDC_CAL_EN_BIT  6
`define GDC_DEC_LSB     0
`define GDC_TEMP_AV_BIT 3

// One-hot state codes in the low three status bits, with sleep coded as zero.
`define GDC_STS_POR   3'h4
`define GDC_STS_STBY  3'h2
`define GDC_STS_AWAKE 3'h1
`define GDC_STS_SLEEP 3'h0

`endif

// *** gdc_pkg.sv ***
// Types shared by the gyro config block and its decimator.
package gdc_pkg;

  // Operating mode of the sensor core.
  typedef enum logic [1:0] {
    GDC_POWERON = 2'b00,
    GDC_AWAKE   = 2'b01,
    GDC_STANDBY = 2'b10,
    GDC_SLEEP   = 2'b11
  } gdc_mode_t;

  // Whole state of the register bank.
  typedef struct packed {
    logic [2:0] highpass_cutoff_sel;
    logic       highpass_on;
    logic       notch_on;
    logic [1:0] lowpass_order_sel;
    logic [3:0] lowpass_cutoff_sel;
    logic       zero_rate_cal_allow;
    logic [2:0] output_decimation_sel;
    gdc_mode_t  mode;
    logic [2:0] state_code;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       cal_start;
    logic       dsp_restart;
    logic       temp_rd_req;
    logic       rate_rd_req;
    logic       temp_data_avail;
    logic       rate_data_avail;
    logic       detect_on;
    logic       highpass_run;
  } gdc_regs_st_t;

  // Whole state of the output decimator.
  typedef struct packed {
    logic [6:0] phase;
    logic       keep;
  } gdc_dec_st_t;

endpackage

// *** gdc_decim.sv ***
// Output-rate decimator: keeps one converter sample in every 2**sel.
`timescale 1ns/1ns
`default_nettype none

module gdc_decim
  import gdc_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Sample stream and control.
  input  wire logic       sample_tick,
  input  wire logic       restart,
  input  wire logic [2:0] dec_sel,
  // Kept-sample strobe.
  output var  logic       keep
);

  gdc_dec_st_t s_q;
  gdc_dec_st_t s_d;

  // Low bits of the phase counter that must all be zero on a kept sample.
  function automatic logic [6:0] ratio_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = 8'h01 << sel;
    return 7'(m - 8'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // The phase restarts with the datapath so the first sample after the restart cycle is kept; a tick in that cycle is dropped.
  always_comb begin
    s_d      = s_q;
    s_d.keep = 1'b0;
    if (restart) begin
      s_d.phase = 7'h00;
    end else if (sample_tick) begin
      s_d.keep  = ((s_q.phase & ratio_mask(dec_sel)) == 7'h00);
      s_d.phase = s_q.phase + 7'h01;
    end
  end

  // State register.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign keep = s_q.keep;

endmodule // gdc_decim

`default_nettype wire

// *** gdc_regs.sv ***
// Gyro DSP configuration registers, state control and address-only commands.
`timescale 1ns/1ns
`default_nettype none

`include "gdc_cfg.svh"

module gdc_regs
  import gdc_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       reset,

  // Register access from the serial front end, same clock.
  input  wire logic       acc_valid,
  input  wire logic [7:0] acc_addr,
  input  wire logic       acc_write,
  input  wire logic [7:0] acc_wdata,

  // Read answer.
  output var  logic       rd_valid,
  output var  logic [7:0] rd_data,

  // Data-read requests to the framing logic.
  output var  logic       temp_rd_req,
  output var  logic       rate_rd_req,

  // Datapath status, same clock.
  input  wire logic       temp_ready,
  input  wire logic       rate_ready,
  input  wire logic       adc_sample_tick,

  // Filter configuration.
  output var  logic [2:0] highpass_cutoff_sel,
  output var  logic       highpass_on,
  output var  logic       highpass_run,
  output var  logic       notch_on,
  output var  logic [1:0] lowpass_order_sel,
  output var  logic [3:0] lowpass_cutoff_sel,
  output var  logic [2:0] output_decimation_sel,
  output var  logic       rate_sample_keep,

  // Calibration and operating state.
  output var  logic       zero_rate_cal_allow,
  output var  logic       cal_start,
  output var  logic       dsp_restart,
  output var  logic       detect_on,
  output var  logic       temp_data_avail,
  output var  logic       rate_data_avail,
  output var  logic [2:0] state_code
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  // One packed image holds every field, pulse and flag of the bank, so a
  // single register stage decides what the host and the datapath see and
  // no output but rate_sample_keep, registered in gdc_decim, can lag another by a cycle.

  gdc_regs_st_t s_q;
  gdc_regs_st_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Functions.
  // Decoding that the next-state logic and the read path both need lives
  // here, so the two can never disagree about a field's position.

  // Default image of the whole bank, used at power-on and by software reset.
  function automatic gdc_regs_st_t bank_defaults();
    gdc_regs_st_t d;
    logic [7:0]   h;
    logic [7:0]   l;
    logic [7:0]   c;
    d = '0;
    h = `GDC_HPF_RST;
    l = `GDC_LPF_RST;
    c = `GDC_CAL_RST;
    d.highpass_cutoff_sel   = h[`GDC_HPF_CUT_LSB +: 3];
    d.highpass_on           = h[`GDC_HPF_ON_BIT];
    d.notch_on              = l[`GDC_NOTCH_BIT];
    d.lowpass_order_sel     = l[`GDC_LPF_ORD_LSB +: 2];
    d.lowpass_cutoff_sel    = l[`GDC_LPF_CUT_LSB +: 4];
    d.zero_rate_cal_allow   = c[`GDC_CAL_EN_BIT];
    d.output_decimation_sel = c[`GDC_DEC_LSB +: 3];
    d.mode                  = GDC_POWERON;
    d.detect_on             = 1'b1;
    d.state_code            = `GDC_STS_POR;
    return d;
  endfunction

  // One-hot status code for a mode, zero for sleep; the enum has exactly four members,
  // so no other pattern can be produced.
  function automatic logic [2:0] mode_code(input gdc_mode_t m);
    logic [2:0] c;
    c = `GDC_STS_SLEEP;
    unique case (m)
      GDC_POWERON: c = `GDC_STS_POR;
      GDC_STANDBY: c = `GDC_STS_STBY;
      GDC_AWAKE:   c = `GDC_STS_AWAKE;
      GDC_SLEEP:   c = `GDC_STS_SLEEP;
    endcase
    return c;
  endfunction

  // True when the detection path is active and data may become available.
  // Power-on counts as running: the sensor detects from the moment it is
  // supplied, and only sleep or standby stop it.
  function automatic logic mode_runs(input gdc_mode_t m);
    return (m == GDC_POWERON) || (m == GDC_AWAKE);
  endfunction

  // Read image of a register; reserved bits read their fixed defaults.
  // Storing only the defined fields keeps the bank small and makes a
  // reserved bit read back the same whatever the host wrote there.
  function automatic logic [7:0] read_mux(input logic [7:0]   a,
                                          input gdc_regs_st_t s);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `GDC_ADDR_HPF: begin
        r = `GDC_HPF_RSV;
        r[`GDC_HPF_CUT_LSB +: 3] = s.highpass_cutoff_sel;
        r[`GDC_HPF_ON_BIT]       = s.highpass_on;
      end
      `GDC_ADDR_LPF: begin
        r = `GDC_LPF_RSV;
        r[`GDC_NOTCH_BIT]         = s.notch_on;
        r[`GDC_LPF_ORD_LSB +: 2]  = s.lowpass_order_sel;
        r[`GDC_LPF_CUT_LSB +: 4]  = s.lowpass_cutoff_sel;
      end
      `GDC_ADDR_CAL: begin
        r = `GDC_CAL_RSV;
        r[`GDC_CAL_EN_BIT]    = s.zero_rate_cal_allow;
        r[`GDC_DEC_LSB +: 3]  = s.output_decimation_sel;
      end
      `GDC_ADDR_STAT: begin
        r[2:0]              = mode_code(s.mode);
        r[`GDC_TEMP_AV_BIT] = s.temp_data_avail;
      end
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  // Pulses default low every cycle; register fields hold unless written.
  // Reserved bits are not stored at all, so a stray host write to them
  // cannot disturb anything.
  // Every field of the next image is settled here once, so the single
  // register below always sees a whole, consistent bank and no half
  // written struct can reach the outputs.
  always_comb begin
    s_d             = s_q;
    s_d.rd_valid    = 1'b0;
    s_d.cal_start   = 1'b0;
    s_d.dsp_restart = 1'b0;
    s_d.temp_rd_req = 1'b0;
    s_d.rate_rd_req = 1'b0;

    if (acc_valid) begin
      case (acc_addr)
        // Configuration registers stay writable in every mode.
        `GDC_ADDR_HPF: begin
          if (acc_write) begin
            s_d.highpass_cutoff_sel = acc_wdata[`GDC_HPF_CUT_LSB +: 3];
            s_d.highpass_on         = acc_wdata[`GDC_HPF_ON_BIT];
          end else begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data  = read_mux(acc_addr, s_q);
          end
        end

        // Lowpass and notch settings; unusable codes are stored as written,
        // so keeping them out of the filter is up to the host.
        `GDC_ADDR_LPF: begin
          if (acc_write) begin
            s_d.notch_on           = acc_wdata[`GDC_NOTCH_BIT];
            s_d.lowpass_order_sel  = acc_wdata[`GDC_LPF_ORD_LSB +: 2];
            s_d.lowpass_cutoff_sel = acc_wdata[`GDC_LPF_CUT_LSB +: 4];
          end else begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data  = read_mux(acc_addr, s_q);
          end
        end

        // Calibration enable and output rate; clearing the enable also makes
        // any later calibration command a no-op.
        `GDC_ADDR_CAL: begin
          if (acc_write) begin
            s_d.zero_rate_cal_allow   = acc_wdata[`GDC_CAL_EN_BIT];
            s_d.output_decimation_sel = acc_wdata[`GDC_DEC_LSB +: 3];
          end else begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data  = read_mux(acc_addr, s_q);
          end
        end

        // Status is read-only; a write is dropped silently.
        `GDC_ADDR_STAT: begin
          if (!acc_write) begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data  = read_mux(acc_addr, s_q);
          end
        end

        // Address-only commands: the write flag and data are ignored.
        // Sleep is entered from any mode; only sleep-out or software reset brings the core back.
        `GDC_ADDR_SLEEP_IN: begin
          s_d.mode = GDC_SLEEP;
        end

        // Sleep-out also restarts the datapath when the core was already
        // awake, so the host can use it to flush the filters.
        `GDC_ADDR_SLEEP_OUT: begin
          s_d.mode        = GDC_AWAKE;
          s_d.dsp_restart = 1'b1;
        end

        // Standby is refused while asleep; otherwise a sleeping core could be
        // moved into a mode that the host believes it never entered.
        `GDC_ADDR_STANDBY: begin
          if (s_q.mode != GDC_SLEEP) begin
            s_d.mode = GDC_STANDBY;
          end
        end

        // Calibration fires at once and only while the host allows it.
        `GDC_ADDR_ZERO_CAL: begin
          // Sleep blocks calibration, as it blocks standby; data reads and software reset still run.
          if (s_q.zero_rate_cal_allow && (s_q.mode != GDC_SLEEP)) begin
            s_d.cal_start = 1'b1;
          end
        end

        // Data reads hand the transfer to the framing logic.
        `GDC_ADDR_TEMP_RD: begin
          s_d.temp_rd_req = !acc_write;
        end
        `GDC_ADDR_RATE_RD: begin
          s_d.rate_rd_req = !acc_write;
        end

        // Software reset reloads the whole default image; pending pulses and
        // the read buffer are cleared with it.
        `GDC_ADDR_SW_RST: begin
          s_d = bank_defaults();
        end

        // Unmapped read answers zero so the front end never waits.
        default: begin
          if (!acc_write) begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data  = 8'h00;
          end
        end
      endcase
    end

    // Derived controls follow the mode that takes effect this edge, so the
    // flags drop in the same cycle the mode leaves normal operation.
    s_d.detect_on       = mode_runs(s_d.mode);
    s_d.temp_data_avail = temp_ready && mode_runs(s_d.mode);
    s_d.rate_data_avail = rate_ready && mode_runs(s_d.mode);
    s_d.highpass_run    = s_d.highpass_on && mode_runs(s_d.mode);
    s_d.state_code      = mode_code(s_d.mode);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset takes the constant default image.
  // The default image is built from constants only, so the asynchronous
  // branch never depends on logic that is itself being reset.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= bank_defaults();
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output decimation; restarted with the datapath on sleep-out, and it
  // only counts while detection runs.
  // Ticks that arrive in standby or sleep are dropped rather than counted,
  // so the output phase does not drift while the core is idle.
  gdc_decim u_decim (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .sample_tick (adc_sample_tick && s_q.detect_on),
    .restart     (s_q.dsp_restart),
    .dec_sel     (s_q.output_decimation_sel),
    .keep        (rate_sample_keep)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.
  // Read answer and data-read requests.
  assign rd_valid              = s_q.rd_valid;
  assign rd_data               = s_q.rd_data;
  assign temp_rd_req           = s_q.temp_rd_req;
  assign rate_rd_req           = s_q.rate_rd_req;

  // Filter configuration fields.
  assign highpass_cutoff_sel   = s_q.highpass_cutoff_sel;
  assign highpass_on           = s_q.highpass_on;
  assign highpass_run          = s_q.highpass_run;
  assign notch_on              = s_q.notch_on;
  assign lowpass_order_sel     = s_q.lowpass_order_sel;
  assign lowpass_cutoff_sel    = s_q.lowpass_cutoff_sel;
  assign output_decimation_sel = s_q.output_decimation_sel;

  // Calibration controls and datapath pulses.
  assign zero_rate_cal_allow   = s_q.zero_rate_cal_allow;
  assign cal_start             = s_q.cal_start;
  assign dsp_restart           = s_q.dsp_restart;

  // Operating state and data flags; the state code is registered with the
  // mode, so it is one-hot or zero on every cycle.
  assign detect_on             = s_q.detect_on;
  assign temp_data_avail       = s_q.temp_data_avail;
  assign rate_data_avail       = s_q.rate_data_avail;
  assign state_code            = s_q.state_code;

endmodule // gdc_regs

`default_nettype wire

// *** gdc_regs_properties.sv ***
// Port-level checker of the gyro config block, bound to its top module.
`timescale 1ns/1ns
`default_nettype none

module gdc_regs_properties (
  // Clock and reset.
  input wire logic       sys_clk,
  input wire logic       reset,
  // Access port.
  input wire logic       acc_valid,
  input wire logic [7:0] acc_addr,
  input wire logic       acc_write,
  input wire logic       rd_valid,
  input wire logic       temp_rd_req,
  input wire logic       rate_rd_req,
  // State and flags.
  input wire logic       temp_ready,
  input wire logic       highpass_on,
  input wire logic       highpass_run,
  input wire logic       zero_rate_cal_allow,
  input wire logic       cal_start,
  input wire logic       dsp_restart,
  input wire logic       detect_on,
  input wire logic       temp_data_avail,
  input wire logic       rate_data_avail,
  input wire logic [2:0] state_code
);
  // All checks use one clock and rest while reset is high.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  //////////////////////////////////////////////////////////////////////////////
  // Legal state codes and mode changes made by address-only commands.
  a_state_legal: assert property (
    state_code inside {3'h4, 3'h2, 3'h1, 3'h0}) else $error("state code illegal");
  a_sleep_enter: assert property (
    acc_valid && acc_addr == 8'h05 |=> state_code == 3'h0) else $error("no sleep");
  a_wake_restart: assert property (
    acc_valid && acc_addr == 8'h06 |=> state_code == 3'h1 && dsp_restart && detect_on)
    else $error("sleep-out failed");
  a_standby_enter: assert property (
    acc_valid && acc_addr == 8'h07 && state_code != 3'h0 |=> state_code == 3'h2 && !detect_on)
    else $error("standby failed");
  a_sleep_holds: assert property (
    acc_valid && acc_addr == 8'h07 && state_code == 3'h0 |=> state_code == 3'h0)
    else $error("standby left sleep");
  a_soft_reset: assert property (
    acc_valid && acc_addr == 8'h09 |=> state_code == 3'h4 && !highpass_on && !zero_rate_cal_allow)
    else $error("software reset incomplete");

  //////////////////////////////////////////////////////////////////////////////
  // Flags, answers and pulses; the past-state terms skip the switching cycle.
  a_avail_gated: assert property (
    state_code inside {3'h2, 3'h0} && $past(state_code) inside {3'h2, 3'h0}
    |-> !temp_data_avail && !rate_data_avail) else $error("avail flag while idle");
  a_temp_follow: assert property (
    !$past(reset) && state_code inside {3'h4, 3'h1} && $past(state_code) inside {3'h4, 3'h1}
    |-> temp_data_avail == $past(temp_ready)) else $error("temp flag wrong");
  a_cal_source: assert property (
    cal_start |-> $past(acc_valid) && $past(acc_addr) == 8'h0c && $past(zero_rate_cal_allow))
    else $error("stray calibration");
  a_cal_sleep: assert property (
    acc_valid && acc_addr == 8'h0c && state_code == 3'h0 |=> !cal_start)
    else $error("calibration in sleep");
  a_read_answer: assert property (
    acc_valid && !acc_write && acc_addr inside {[8'h01:8'h04]} |=> rd_valid)
    else $error("no read answer");
  a_cmd_silent: assert property (
    acc_valid && acc_addr inside {8'h05, 8'h06, 8'h07, 8'h09, 8'h0c} |=> !rd_valid)
    else $error("command gave data");
  a_data_reads: assert property (
    acc_valid && !acc_write && acc_addr == 8'h0a |=> rate_rd_req && !rd_valid)
    else $error("rate read request missing");
  a_temp_read: assert property (
    acc_valid && !acc_write && acc_addr == 8'h08 |=> temp_rd_req && !rd_valid)
    else $error("temp read request missing");
  a_hpf_gate: assert property (
    highpass_run |-> highpass_on && detect_on) else $error("highpass runs unenabled");
endmodule // gdc_regs_properties

bind gdc_regs gdc_regs_properties gdc_regs_properties_i (.sys_clk, .reset, .acc_valid,
  .acc_addr, .acc_write, .rd_valid, .temp_rd_req, .rate_rd_req, .temp_ready, .highpass_on,
  .highpass_run, .zero_rate_cal_allow, .cal_start, .dsp_restart, .detect_on,
  .temp_data_avail, .rate_data_avail, .state_code);

`default_nettype wire

// *** gdc_host_model.sv ***
// Host controller model issuing single register accesses to the config block.
`timescale 1ns/1ns
`default_nettype none

module gdc_host_model (
  // Clock.
  input  wire logic       sys_clk,
  // Access port toward the block.
  output var  logic       acc_valid,
  output var  logic [7:0] acc_addr,
  output var  logic       acc_write,
  output var  logic [7:0] acc_wdata,
  // Read answer.
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data
);
  // Idle bus at time zero.
  initial begin
    acc_valid = 1'b0;
    acc_addr  = 8'h00;
    acc_write = 1'b0;
    acc_wdata = 8'h00;
  end

  // Reserved bits go out at their defaults and unusable codes are pulled back.
  function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h01: legal = {1'b0, (d[6:4] == 3'h7) ? 3'h6 : d[6:4], 2'h0, d[1], 1'b1};
      8'h02: legal = {1'b0, d[6], (d[5:4] == 2'h3) ? 2'h2 : d[5:4],
                      (d[3:0] > 4'hd) ? 4'hd : d[3:0]};
      8'h03: legal = {1'b0, d[6], 3'h0, d[2:0]};
      default: legal = d;
    endcase
  endfunction

  // One access taken at a single edge; afterwards address and data show inverted junk.
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic v, output logic [7:0] q);
    @(posedge sys_clk);
    acc_valid <= 1'b1;
    acc_addr  <= a;
    acc_write <= w;
    acc_wdata <= legal(a, d);
    @(posedge sys_clk);
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
    acc_wdata <= ~d;
    #1;
    v = rd_valid;
    q = rd_data;
  endtask
endmodule // gdc_host_model

`default_nettype wire

// *** gdc_regs_tb.sv ***
// Self-checking testbench of the gyro config block.
`timescale 1ns/1ns
`default_nettype none

module gdc_regs_tb;
  logic       sys_clk, reset, acc_valid, acc_write, rd_valid, temp_rd_req, rate_rd_req;
  logic       temp_ready, rate_ready, adc_sample_tick, highpass_on, highpass_run, notch_on;
  logic       rate_sample_keep, zero_rate_cal_allow, cal_start, dsp_restart, detect_on;
  logic       temp_data_avail, rate_data_avail, v;
  logic [7:0] acc_addr, acc_wdata, rd_data, q, a, d;
  logic [7:0] img [1:3];
  logic [3:0] lowpass_cutoff_sel;
  logic [2:0] highpass_cutoff_sel, output_decimation_sel, state_code;
  logic [1:0] lowpass_order_sel;
  int         err_count = 0;
  int         n_checks = 0;

  gdc_regs gdc_regs_i (.sys_clk, .reset, .acc_valid, .acc_addr, .acc_write, .acc_wdata,
    .rd_valid, .rd_data, .temp_rd_req, .rate_rd_req, .temp_ready, .rate_ready,
    .adc_sample_tick, .highpass_cutoff_sel, .highpass_on, .highpass_run, .notch_on,
    .lowpass_order_sel, .lowpass_cutoff_sel, .output_decimation_sel, .rate_sample_keep,
    .zero_rate_cal_allow, .cal_start, .dsp_restart, .detect_on, .temp_data_avail,
    .rate_data_avail, .state_code);
  gdc_host_model gdc_host_model_i (.sys_clk, .acc_valid, .acc_addr, .acc_write, .acc_wdata,
    .rd_valid, .rd_data);

  // 10 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Comparison, verdict and expectation helpers.
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic logic [7:0] stat(input logic [2:0] st, input logic t);
    stat = {4'h0, t, st};
  endfunction
  function automatic int keeps(input int s, input int t);
    keeps = (t + (1 << s) - 1) >> s;
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [7:0] dd);
    gdc_host_model_i.acc(ad, 1'b1, dd, v, q);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    gdc_host_model_i.acc(ad, 1'b0, 8'h00, v, q);
    chk("rd_valid", v, 8'h01);
    chk("rd_data", q, e);
  endtask
  // Feeds converter ticks and counts kept samples, one cycle behind.
  task automatic dec(input int t, input int e);
    int k;
    k = 0;
    for (int i = 0; i < t + 2; i++) begin
      @(posedge sys_clk);
      adc_sample_tick <= (i < t);
      #1;
      k += rate_sample_keep;
    end
    chk("keeps", 8'(k), 8'(e));
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    print_verdict;
  end

  // Main sequence.
  initial begin
    reset = 1'b1;
    temp_ready = 1'b0;
    rate_ready = 1'b0;
    adc_sample_tick = 1'b0;
    void'($urandom(32'h7abc));
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h01, 8'h21);
    rd(8'h02, 8'h06);
    rd(8'h03, 8'h00);
    wr(8'h04, 8'hff);
    rd(8'h04, stat(3'h4, 1'b0));
    rd(8'h0d, 8'h00);
    @(posedge sys_clk);
    temp_ready <= 1'b1;
    rate_ready <= 1'b1;
    wr(8'h01, 8'h63);
    chk("hpf_run", {highpass_run, highpass_cutoff_sel}, 8'h0e);
    rd(8'h04, stat(3'h4, 1'b1));
    wr(8'h07, 8'h00);
    chk("hpf_run", highpass_run, 8'h00);
    rd(8'h04, stat(3'h2, 1'b0));
    chk("rate_avail", 8'(rate_data_avail), 8'h00);
    wr(8'h05, 8'h00);
    wr(8'h07, 8'h00);
    rd(8'h04, stat(3'h0, 1'b0));
    wr(8'h03, 8'h40);
    wr(8'h0c, 8'h00);
    chk("cal_start", cal_start, 8'h00);
    rd(8'h03, 8'h40);
    wr(8'h06, 8'h00);
    chk("restart", {dsp_restart, detect_on}, 8'h03);
    rd(8'h04, stat(3'h1, 1'b1));
    chk("rate_avail", 8'(rate_data_avail), 8'h01);
    wr(8'h0c, 8'h00);
    chk("cal_start", cal_start, 8'h01);
    wr(8'h03, 8'h00);
    wr(8'h0c, 8'h00);
    chk("cal_start", cal_start, 8'h00);
    gdc_host_model_i.acc(8'h08, 1'b0, 8'h00, v, q);
    chk("temp_req", {v, temp_rd_req}, 8'h01);
    wr(8'h08, 8'h5a);
    chk("temp_req", temp_rd_req, 8'h00);
    wr(8'h0a, 8'h5a);
    chk("rate_req", rate_rd_req, 8'h00);
    // Random legal settings read back through the register port.
    img[1] = 8'h63;
    img[2] = 8'h06;
    img[3] = 8'h00;
    repeat (30) begin
      a = 8'h01 + 8'($urandom_range(2));
      d = 8'($urandom);
      @(posedge sys_clk) temp_ready <= 1'($urandom);
      wr(a, d);
      img[a] = gdc_host_model_i.legal(a, d);
      rd(a, img[a]);
    end
    chk("hpf", 8'({highpass_on, highpass_cutoff_sel}),
        8'({img[1][1], img[1][6:4]}));
    chk("fields", 8'({notch_on, lowpass_order_sel, lowpass_cutoff_sel}),
        {1'b0, img[2][6:0]});
    chk("dec_sel", 8'(output_decimation_sel), {5'h00, img[3][2:0]});
    chk("cal_allow", 8'(zero_rate_cal_allow), {7'h00, img[3][6]});
    wr(8'h09, 8'h00);
    rd(8'h01, 8'h21);
    rd(8'h02, 8'h06);
    // Every output-rate code, restarted first; ticks stop counting in standby.
    for (int s = 0; s < 8; s++) begin
      wr(8'h03, 8'(s));
      wr(8'h06, 8'h00);
      repeat (2) @(posedge sys_clk);
      dec(5 * (1 << s) + 1, keeps(s, 5 * (1 << s) + 1));
    end
    wr(8'h07, 8'h00);
    dec(6, 0);
    print_verdict;
  end
endmodule // gdc_regs_tb

`default_nettype wire
